// ==== rtl/channel_gate.sv ====
// One lamp channel: alternating gate pair with peak-current on-time control.
`timescale 1ns/100ps
module channel_gate #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Timing from the lamp clock, and the burst run enable
	input  wire logic [W-1:0] rel_in,
	input  wire logic [W-1:0] half_in,
	input  wire logic         start_in,
	input  wire logic         run_in,
	// Lamp current comparator
	input  wire logic         peak_in,
	// Gate drives
	output logic              gate_a_out,
	output logic              gate_b_out
);
	logic [W-1:0] on_q;
	logic [W-1:0] max_on;
	logic [W-1:0] on_eff;
	logic         peak_seen_q;

	// Each gate stays on at most half a period minus the dead time.
	always_comb
	begin
		max_on = (half_in > W'(lamp_drive_pkg::DEAD_CYCLES)) ? half_in - W'(lamp_drive_pkg::DEAD_CYCLES) : '0;
		on_eff = (on_q > max_on) ? max_on : on_q;
	end

	// Peak seen during a lamp cycle.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			peak_seen_q <= 1'b0;
		else if (start_in)
			peak_seen_q <= peak_in;
		else if (peak_in)
			peak_seen_q <= 1'b1;
	end

	// Shorten the on-time after a peak over reference, lengthen it otherwise.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			on_q <= W'(lamp_drive_pkg::ON_INIT);
		else if (start_in && run_in)
		begin
			if (peak_seen_q)
				on_q <= (on_q > W'(lamp_drive_pkg::ON_STEP)) ? on_q - W'(lamp_drive_pkg::ON_STEP) : '0;
			else if (on_q < max_on)
				on_q <= on_q + W'(lamp_drive_pkg::ON_STEP);
		end
	end

	// Gate A in the first half, gate B in the second, never together.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			gate_a_out <= 1'b0;
			gate_b_out <= 1'b0;
		end
		else
		begin
			gate_a_out <= run_in && (rel_in < on_eff);
			gate_b_out <= run_in && (rel_in >= half_in) && (rel_in - half_in < on_eff);
		end
	end
endmodule : channel_gate

// ==== rtl/lamp_drive_burst_dimming_control.sv ====
// Top of the eight-channel lamp drive controller.
// Notes on behaviour
// - Burst high drives enabled channels at lamp frequency.
// - Burst low holds every gate output off.
// - Burst source bit selects internal or external.
// - Dimming clock from pin or internal oscillator.
// - Dim level maps linearly from minimum to full.
// - Internal burst driven out on dimming sync.
// - Receiver takes sync pin, ignores dim inputs.
// - Lamp clock source bit selects internal or external.
// - Internal lamp clock driven out on sync.
// - Gate turn-ons spread evenly over eight channels.
// - Burst gating hits all channels at once.
// - Gates alternate; on-time sets lamp current.
// - Peak current against reference sets duty.
// - Profile and control bytes reachable over serial.
// - Eight user bytes reachable over serial.
// - Configuration holds factory defaults until rewritten.
// - Slave address follows the address select pin.
`timescale 1ns/100ps
module lamp_drive_burst_dimming_control #(
	parameter int LAMP_PERIOD = lamp_drive_pkg::LAMP_PERIOD_CYCLES,
	parameter int DIM_PERIOD  = lamp_drive_pkg::DIM_PERIOD_CYCLES
) (
	// Clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	// Channel control
	input  wire logic [7:0] channel_enable_in,
	input  wire logic [7:0] dim_level_code_in,
	input  wire logic [7:0] lamp_current_sense_input_in,
	// Dimming and lamp timing pins
	input  wire logic       dimming_oscillator_pin_in,
	input  wire logic       dimming_sync_pin_in,
	output logic            dimming_sync_pin_out,
	output logic            dimming_sync_pin_oe_out,
	input  wire logic       lamp_sync_pin_in,
	output logic            lamp_sync_pin_out,
	output logic            lamp_sync_pin_oe_out,
	// Serial port
	input  wire logic       address_select_pin_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	// Gate drives and status
	output logic [7:0]      gate_a_out,
	output logic [7:0]      gate_b_out,
	output logic            burst_modulation_out
);
	localparam int LW = lamp_drive_pkg::LAMP_CNT_W;
	localparam int DW = lamp_drive_pkg::DIM_CNT_W;

	// ------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------
	if (LAMP_PERIOD < 16 || LAMP_PERIOD >= (1 << LW))
		$error("LAMP_PERIOD out of range");
	if (DIM_PERIOD < 256 || DIM_PERIOD >= (1 << DW))
		$error("DIM_PERIOD out of range");

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [8:0] burst_duty(input logic [7:0] code);
		logic [15:0] span;
		span = 16'(code - lamp_drive_pkg::DIM_LOW_CODE) * 16'(lamp_drive_pkg::DIM_FULL_DUTY - lamp_drive_pkg::DIM_MIN_DUTY);
		if (code <= lamp_drive_pkg::DIM_LOW_CODE)
			return lamp_drive_pkg::DIM_MIN_DUTY;
		if (code >= lamp_drive_pkg::DIM_HIGH_CODE)
			return lamp_drive_pkg::DIM_FULL_DUTY;
		return 9'(lamp_drive_pkg::DIM_MIN_DUTY + 9'(span / 16'(lamp_drive_pkg::DIM_HIGH_CODE - lamp_drive_pkg::DIM_LOW_CODE)));
	endfunction : burst_duty

	function automatic logic [7:0] default_byte(input int idx);
		if (idx < int'(lamp_drive_pkg::CR1_ADDR))
			return lamp_drive_pkg::SSP_RESET;
		if (idx == int'(lamp_drive_pkg::CR1_ADDR))
			return lamp_drive_pkg::CR1_RESET;
		if (idx == int'(lamp_drive_pkg::CR2_ADDR))
			return lamp_drive_pkg::CR2_RESET;
		return lamp_drive_pkg::USER_RESET;
	endfunction : default_byte

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [5:0] pins_s;
	logic [7:0] sense_s;
	logic       lamp_sync_s;
	logic       dim_sync_s;
	logic       dim_osc_s;
	logic       scl_s;
	logic       sda_s;
	logic       addr_sel_s;

	pin_sync #(.W(14)) u_pin_sync (
		.clk_in    (core_clk_in),
		.rst_n_in  (rst_n_in),
		.pin_in    ({lamp_current_sense_input_in, address_select_pin_in, sda_in, scl_in,
		             dimming_oscillator_pin_in, dimming_sync_pin_in, lamp_sync_pin_in}),
		.level_out ({sense_s, pins_s})
	);

	assign {addr_sel_s, sda_s, scl_s, dim_osc_s, dim_sync_s, lamp_sync_s} = pins_s;

	// ------------------------------------------------------------------
	// Configuration memory
	// ------------------------------------------------------------------
	logic [7:0] mem_q [lamp_drive_pkg::MEM_BYTES];
	logic       mem_we;
	logic [7:0] mem_wptr;
	logic [7:0] mem_wdata;
	logic [7:0] cr1;

	// Factory defaults until a serial write.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < lamp_drive_pkg::MEM_BYTES; i++)
				mem_q[i] <= default_byte(i);
		end
		else if (mem_we && mem_wptr <= lamp_drive_pkg::MEM_LAST)
			mem_q[mem_wptr[3:0]] <= mem_wdata;
	end

	assign cr1 = mem_q[lamp_drive_pkg::CR1_ADDR[3:0]];

	// ------------------------------------------------------------------
	// Burst modulation
	// ------------------------------------------------------------------
	logic          burst_ext_sel;
	logic          dim_ext_sel;
	logic          dim_osc_p_q;
	logic          dim_edge;
	logic [DW-1:0] dim_cnt_q;
	logic [DW-1:0] dim_period_q;
	logic [31:0]   dim_thresh;
	logic [8:0]    duty;
	logic          burst_int_q;

	assign burst_ext_sel = cr1[lamp_drive_pkg::CR1_BURST_SRC_BIT];
	assign dim_ext_sel   = cr1[lamp_drive_pkg::CR1_DIM_CLK_SRC_BIT];
	assign duty          = burst_duty(dim_level_code_in);
	assign dim_thresh    = (32'(dim_period_q) * 32'(duty)) >> 8;
	// Dimming clock edge from the pin or from the internal divider.
	assign dim_edge      = dim_ext_sel ? (dim_osc_s && !dim_osc_p_q)
	                                   : (dim_cnt_q >= DW'(DIM_PERIOD - 1));

	// The period of an external dimming clock is measured, so duty follows any rate in range.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			dim_osc_p_q  <= 1'b0;
			dim_cnt_q    <= '0;
			dim_period_q <= DW'(DIM_PERIOD);
		end
		else
		begin
			dim_osc_p_q <= dim_osc_s;
			if (dim_edge)
			begin
				dim_cnt_q    <= '0;
				dim_period_q <= dim_ext_sel ? dim_cnt_q + DW'(1) : DW'(DIM_PERIOD);
			end
			else if (dim_cnt_q != '1)
				dim_cnt_q <= dim_cnt_q + DW'(1);
		end
	end

	// Internal burst is high for the duty fraction of each dimming period.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			burst_int_q <= 1'b0;
		else
			burst_int_q <= (duty == lamp_drive_pkg::DIM_FULL_DUTY) || (32'(dim_cnt_q) < dim_thresh);
	end

	// Registered once and shared by every channel; a receiver ignores the dim inputs.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			burst_modulation_out <= 1'b0;
		else
			burst_modulation_out <= burst_ext_sel ? dim_sync_s : burst_int_q;
	end

	// Only an internal source with the burst output bit clear drives the pin.
	assign dimming_sync_pin_out    = burst_int_q;
	assign dimming_sync_pin_oe_out = !burst_ext_sel && !cr1[lamp_drive_pkg::CR1_BURST_OUT_BIT];

	// ------------------------------------------------------------------
	// Lamp clock
	// ------------------------------------------------------------------
	logic          lamp_ext_sel;
	logic          lamp_sync_p_q;
	logic          lamp_edge;
	logic [LW-1:0] lamp_phase_q;
	logic [LW-1:0] lamp_period_q;
	logic [LW-1:0] lamp_half;

	assign lamp_ext_sel = cr1[lamp_drive_pkg::CR1_LAMP_CLK_SRC_BIT];
	assign lamp_half    = lamp_period_q >> 1;
	assign lamp_edge    = lamp_ext_sel ? (lamp_sync_s && !lamp_sync_p_q)
	                                   : (lamp_phase_q >= LW'(LAMP_PERIOD - 1));

	// Slower external lamp clocks saturate the count.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			lamp_sync_p_q <= 1'b0;
			lamp_phase_q  <= '0;
			lamp_period_q <= LW'(LAMP_PERIOD);
		end
		else
		begin
			lamp_sync_p_q <= lamp_sync_s;
			if (lamp_edge)
			begin
				lamp_phase_q  <= '0;
				lamp_period_q <= lamp_ext_sel ? lamp_phase_q + LW'(1) : LW'(LAMP_PERIOD);
			end
			else if (lamp_phase_q != '1)
				lamp_phase_q <= lamp_phase_q + LW'(1);
		end
	end

	// Lamp clock out, high in the first half.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			lamp_sync_pin_out <= 1'b0;
		else
			lamp_sync_pin_out <= lamp_phase_q < lamp_half;
	end

	assign lamp_sync_pin_oe_out = !lamp_ext_sel;

	// ------------------------------------------------------------------
	// Channels with staggered phase
	// ------------------------------------------------------------------
	for (genvar k = 0; k < lamp_drive_pkg::CHANNELS; k++)
	begin : g_ch
		logic [15:0]   off_prod;
		logic [LW-1:0] offset;
		logic [LW-1:0] rel;

		// Channel k starts k eighths of a period after channel 0.
		assign off_prod = 16'(lamp_period_q) * 16'(k);
		assign offset   = off_prod[LW+2:3];
		assign rel      = (lamp_phase_q >= offset) ? lamp_phase_q - offset : lamp_phase_q + lamp_period_q - offset;

		channel_gate #(.W(LW)) u_gate (
			.clk_in     (core_clk_in),
			.rst_n_in   (rst_n_in),
			.rel_in     (rel),
			.half_in    (lamp_half),
			.start_in   (rel == '0),
			.run_in     (burst_modulation_out && channel_enable_in[k]),
			.peak_in    (sense_s[k]),
			.gate_a_out (gate_a_out[k]),
			.gate_b_out (gate_b_out[k])
		);
	end

	// ------------------------------------------------------------------
	// Serial slave
	// ------------------------------------------------------------------
	lamp_drive_pkg::i2c_state_e state_q;
	logic       scl_p_q;
	logic       sda_p_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic       rw_q;
	logic       first_q;
	logic       nack_q;
	logic       oe_q;
	logic       i2c_start;
	logic       i2c_stop;
	logic       scl_rise;
	logic       scl_fall;
	logic [6:0] my_addr;
	logic [7:0] rd_byte;
	logic [7:0] ptr_next;

	assign i2c_start = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign i2c_stop  = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign scl_rise  = scl_s && !scl_p_q;
	assign scl_fall  = !scl_s && scl_p_q;
	assign my_addr   = lamp_drive_pkg::I2C_ADDR_BASE | {6'h00, addr_sel_s};
	assign rd_byte   = (ptr_q <= lamp_drive_pkg::MEM_LAST) ? mem_q[ptr_q[3:0]] : 8'h00;
	assign ptr_next  = (ptr_q >= lamp_drive_pkg::MEM_LAST) ? 8'h00 : ptr_q + 8'h01;
	assign mem_we    = (state_q == lamp_drive_pkg::I2C_WR_BYTE) && scl_fall && (bit_cnt_q == 4'h8) && !first_q;
	assign mem_wptr  = ptr_q;
	assign mem_wdata = rx_q;
	assign sda_out   = 1'b0;
	assign sda_oe_out = oe_q;

	// Previous bus levels for edge detection.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Bytes are sampled on clock rise; the slave changes its data line only after clock fall.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q   <= lamp_drive_pkg::I2C_IDLE;
			bit_cnt_q <= 4'h0;
			rx_q      <= 8'h00;
			tx_q      <= 8'h00;
			ptr_q     <= 8'h00;
			rw_q      <= 1'b0;
			first_q   <= 1'b0;
			nack_q    <= 1'b0;
			oe_q      <= 1'b0;
		end
		else if (i2c_start)
		begin
			state_q   <= lamp_drive_pkg::I2C_ADDR;
			bit_cnt_q <= 4'h0;
			oe_q      <= 1'b0;
		end
		else if (i2c_stop)
		begin
			state_q <= lamp_drive_pkg::I2C_IDLE;
			oe_q    <= 1'b0;
		end
		else
		begin
			if (scl_rise && bit_cnt_q < 4'h8)
			begin
				rx_q      <= {rx_q[6:0], sda_s};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
			if (scl_rise && state_q == lamp_drive_pkg::I2C_RD_ACK)
				nack_q <= sda_s;
			case (state_q)
				lamp_drive_pkg::I2C_ADDR:
					if (scl_fall && bit_cnt_q == 4'h8)
					begin
						if (rx_q[7:1] == my_addr)
						begin
							state_q <= lamp_drive_pkg::I2C_ADDR_ACK;
							rw_q    <= rx_q[0];
							oe_q    <= 1'b1;
						end
						else
							state_q <= lamp_drive_pkg::I2C_IDLE;
					end
				lamp_drive_pkg::I2C_ADDR_ACK, lamp_drive_pkg::I2C_RD_ACK:
					if (scl_fall)
					begin
						bit_cnt_q <= 4'h0;
						if (state_q == lamp_drive_pkg::I2C_RD_ACK && nack_q)
						begin
							state_q <= lamp_drive_pkg::I2C_IDLE;
							oe_q    <= 1'b0;
						end
						else if (rw_q)
						begin
							state_q <= lamp_drive_pkg::I2C_RD_BYTE;
							tx_q    <= {rd_byte[6:0], 1'b0};
							oe_q    <= !rd_byte[7];
							bit_cnt_q <= 4'h0;
						end
						else
						begin
							state_q <= lamp_drive_pkg::I2C_WR_BYTE;
							first_q <= 1'b1;
							oe_q    <= 1'b0;
						end
					end
				lamp_drive_pkg::I2C_WR_BYTE:
					if (scl_fall && bit_cnt_q == 4'h8)
					begin
						state_q <= lamp_drive_pkg::I2C_WR_ACK;
						oe_q    <= 1'b1;
						first_q <= 1'b0;
						ptr_q   <= first_q ? rx_q : ptr_next;
					end
				lamp_drive_pkg::I2C_WR_ACK:
					if (scl_fall)
					begin
						state_q   <= lamp_drive_pkg::I2C_WR_BYTE;
						oe_q      <= 1'b0;
						bit_cnt_q <= 4'h0;
					end
				lamp_drive_pkg::I2C_RD_BYTE:
					if (scl_fall)
					begin
						if (bit_cnt_q == 4'h8)
						begin
							state_q <= lamp_drive_pkg::I2C_RD_ACK;
							oe_q    <= 1'b0;
							ptr_q   <= ptr_next;
						end
						else
						begin
							oe_q <= !tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				default:
					oe_q <= 1'b0;
			endcase
		end
	end

endmodule : lamp_drive_burst_dimming_control

// ==== rtl/lamp_drive_pkg.sv ====
// Shared constants and types for the eight-channel lamp drive controller.
package lamp_drive_pkg;

	// ------------------------------------------------------------------
	// Sizes and clock rate
	// ------------------------------------------------------------------
	localparam int CHANNELS     = 8;
	localparam int CORE_CLK_MHZ = 100;
	localparam int LAMP_CNT_W   = 12;
	localparam int DIM_CNT_W    = 23;

	// ------------------------------------------------------------------
	// Times and derived cycle counts
	// ------------------------------------------------------------------
	localparam int DEAD_TIME_NS       = 200;
	localparam int DEAD_CYCLES        = (DEAD_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int LAMP_FREQ_KHZ      = 50;
	localparam int LAMP_PERIOD_CYCLES = (CORE_CLK_MHZ * 1000) / LAMP_FREQ_KHZ;
	localparam int DIM_FREQ_HZ        = 200;
	localparam int DIM_PERIOD_CYCLES  = (CORE_CLK_MHZ * 1000000) / DIM_FREQ_HZ;
	localparam logic [11:0] ON_INIT   = 12'h000;
	localparam logic [11:0] ON_STEP   = 12'h001;

	// ------------------------------------------------------------------
	// Configuration memory map and field positions
	// ------------------------------------------------------------------
	localparam int MEM_BYTES            = 14;
	localparam logic [7:0] SSP_BASE     = 8'h00;
	localparam logic [7:0] CR1_ADDR     = 8'h04;
	localparam logic [7:0] CR2_ADDR     = 8'h05;
	localparam logic [7:0] USER_BASE    = 8'h06;
	localparam logic [7:0] MEM_LAST     = 8'h0D;
	localparam int CR1_BURST_SRC_BIT    = 0;
	localparam int CR1_DIM_CLK_SRC_BIT  = 1;
	localparam int CR1_BURST_OUT_BIT    = 2;
	localparam int CR1_LAMP_CLK_SRC_BIT = 3;
	localparam int CR2_RANGE_A_BIT      = 0;
	localparam int CR2_RANGE_B_BIT      = 1;

	// ------------------------------------------------------------------
	// Factory default contents
	// ------------------------------------------------------------------
	localparam logic [7:0] SSP_RESET  = 8'h00;
	localparam logic [7:0] CR1_RESET  = 8'h00;
	localparam logic [7:0] CR2_RESET  = 8'h01;
	localparam logic [7:0] USER_RESET = 8'hFF;

	// ------------------------------------------------------------------
	// Dim level scale, 10 mV per code step
	// ------------------------------------------------------------------
	localparam logic [7:0] DIM_LOW_CODE  = 8'h32;
	localparam logic [7:0] DIM_HIGH_CODE = 8'hC8;
	localparam logic [8:0] DIM_MIN_DUTY  = 9'h01A;
	localparam logic [8:0] DIM_FULL_DUTY = 9'h100;

	// ------------------------------------------------------------------
	// Serial port
	// ------------------------------------------------------------------
	localparam logic [6:0] I2C_ADDR_BASE = 7'h58;  // Arbitrary value.

	typedef enum logic [2:0] {
		I2C_IDLE     = 3'b000,
		I2C_ADDR     = 3'b001,
		I2C_ADDR_ACK = 3'b010,
		I2C_WR_BYTE  = 3'b011,
		I2C_WR_ACK   = 3'b100,
		I2C_RD_BYTE  = 3'b101,
		I2C_RD_ACK   = 3'b110
	} i2c_state_e;

endpackage : lamp_drive_pkg

// ==== rtl/pin_sync.sv ====
// Three-stage input synchroniser with agreement filter for pin inputs.
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Pins and filtered result
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// The first stage feeds only the second, so no logic sees a metastable value.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit changes only once the second and third stages agree.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			level_out <= '0;
		else
			for (int i = 0; i < W; i++)
				if (s2_q[i] == s3_q[i])
					level_out[i] <= s3_q[i];
	end
endmodule : pin_sync

// ==== testbench/lamp_drive_checker.sv ====
// Assertion checker for the lamp drive outputs.
`timescale 1ns/100ps
module lamp_drive_checker #(
	parameter int LAMP_PERIOD = 64
) (
	// Clock, reset and enables
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] channel_enable_in,
	// Watched outputs
	input wire logic [7:0] gate_a_out,
	input wire logic [7:0] gate_b_out,
	input wire logic       burst_modulation_out,
	input wire logic       lamp_sync_pin_out,
	input wire logic       lamp_sync_pin_oe_out,
	input wire logic       dimming_sync_pin_out,
	input wire logic       dimming_sync_pin_oe_out
);
	localparam int STAG  = LAMP_PERIOD / 8;
	localparam int ONMAX = LAMP_PERIOD / 2 - lamp_drive_pkg::DEAD_CYCLES;
	logic [15:0] per_q;
	logic [15:0] wid_q;
	logic        seen_q;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// First rise after a source switch is not judged.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in) seen_q <= 1'b0;
		else seen_q <= lamp_sync_pin_oe_out & (seen_q | $rose(lamp_sync_pin_out));
	end
	// Cycles since the last lamp sync rise.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in) per_q <= 16'h0000;
		else per_q <= $rose(lamp_sync_pin_out) ? 16'h0001 : per_q + 16'h0001;
	end
	// Run length of gate A on channel zero.
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in) wid_q <= 16'h0000;
		else wid_q <= gate_a_out[0] ? wid_q + 16'h0001 : 16'h0000;
	end
	property p_excl; (gate_a_out & gate_b_out) == 8'h00; endproperty
	a_excl: assert property (p_excl) else $error("gate overlap");
	property p_gap; $fell(gate_a_out[0]) |-> !gate_b_out[0] [*8]; endproperty
	a_gap: assert property (p_gap) else $error("no dead gap");
	property p_off; !burst_modulation_out [*3] |-> (gate_a_out | gate_b_out) == 8'h00; endproperty
	a_off: assert property (p_off) else $error("gate on outside burst");
	property p_dis; (~channel_enable_in & ~$past(channel_enable_in, 2) & (gate_a_out | gate_b_out)) == 8'h00; endproperty
	a_dis: assert property (p_dis) else $error("disabled channel driven");
	property p_per; $rose(lamp_sync_pin_out) && seen_q |-> per_q == LAMP_PERIOD; endproperty
	a_per: assert property (p_per) else $error("lamp sync period");
	property p_wid; gate_a_out[0] |-> wid_q < ONMAX; endproperty
	a_wid: assert property (p_wid) else $error("gate on too long");
	property p_phase;
		burst_modulation_out [*8] ##0 lamp_sync_pin_oe_out && $rose(gate_a_out[0])
			|-> ##STAG gate_a_out[1] || !burst_modulation_out;
	endproperty
	a_phase: assert property (p_phase) else $error("phase stagger");
	property p_dsync; dimming_sync_pin_oe_out && $rose(dimming_sync_pin_out) |-> ##[0:2] burst_modulation_out; endproperty
	a_dsync: assert property (p_dsync) else $error("sync out not burst");
	c_ext: cover property (!lamp_sync_pin_oe_out && $rose(gate_a_out[0]));
	c_fall: cover property ($fell(burst_modulation_out));
	c_rx: cover property (!dimming_sync_pin_oe_out && $rose(burst_modulation_out));
endmodule : lamp_drive_checker
bind lamp_drive_burst_dimming_control lamp_drive_checker #(.LAMP_PERIOD(LAMP_PERIOD)) lamp_drive_checker_inst (.*);

// ==== testbench/lamp_peer_model.sv ====
// Far side model: lamp current feedback and a peer controller's clocks.
`timescale 1ns/100ps
module lamp_peer_model #(
	parameter int THR = 6,
	parameter int LP  = 1500,
	parameter int DP  = 800
) (
	// Clock and reset
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	// Gate drives and peer control
	input wire logic [7:0] gate_a_in,
	input wire logic [7:0] gate_b_in,
	input wire logic       lamp_en_in,
	// Feedback and peer clocks
	output logic [7:0]     sense_out,
	output logic           lamp_clk_out,
	output logic           dim_clk_out
);
	logic [3:0]  on_q [8];
	logic [11:0] lc_q;
	logic [11:0] dc_q;
	// Current peaks once a gate has stayed on THR cycles, so on-time settles.
	always_ff @(posedge core_clk_in)
	begin
		for (int k = 0; k < 8; k++)
			on_q[k] <= (!rst_n_in || !(gate_a_in[k] | gate_b_in[k])) ? 4'h0 : on_q[k] + {3'h0, on_q[k] != 4'hF};
	end
	always_comb
	begin
		for (int k = 0; k < 8; k++)
			sense_out[k] = on_q[k] >= THR;
	end
	// Peer lamp clock; low while the peer is idle.
	always_ff @(posedge core_clk_in)
		lc_q <= (!rst_n_in || !lamp_en_in || lc_q == LP - 1) ? 12'h000 : lc_q + 12'h001;
	assign lamp_clk_out = lamp_en_in && lc_q < LP / 2;
	// Time-scaled dimming clock.
	always_ff @(posedge core_clk_in)
		dc_q <= (!rst_n_in || dc_q == DP - 1) ? 12'h000 : dc_q + 12'h001;
	assign dim_clk_out = dc_q < DP / 2;
endmodule : lamp_peer_model

// ==== testbench/test_lamp_drive_burst_dimming_control.sv ====
// Self-checking bench for the lamp drive controller.
`timescale 1ns/100ps
module test_lamp_drive_burst_dimming_control;
	localparam logic [6:0] DEV = lamp_drive_pkg::I2C_ADDR_BASE | 7'h01;
	localparam logic [7:0] C1 = lamp_drive_pkg::CR1_ADDR;
	localparam logic [7:0] C2 = lamp_drive_pkg::CR2_ADDR;
	logic       clk, rst_n, scl, sda_m, pburst, lamp_en, lg, lb;
	logic       lso, lsoe, dso, dsoe, sda_o, sda_oe, burst, plamp, pdim;
	logic [7:0] code, ga, gb, sense;
	logic [8:0] rx;
	int         err_total, cmp_count, hi, rises, brises;
	// Shared pins; a sync line the controller does not drive takes the peer's level, SDA is pulled high.
	wire logic  lamp_sync_pin = lsoe ? lso : plamp;
	wire logic  dsync = dsoe ? dso : pburst;
	wire logic  sda = sda_m & !(sda_oe & !sda_o);
	lamp_drive_burst_dimming_control #(.LAMP_PERIOD(64), .DIM_PERIOD(1024)) lamp_drive_burst_dimming_control_inst (
		.core_clk_in(clk), .rst_n_in(rst_n), .channel_enable_in(8'h7F), .dim_level_code_in(code),
		.lamp_current_sense_input_in(sense), .dimming_oscillator_pin_in(pdim), .dimming_sync_pin_in(dsync),
		.dimming_sync_pin_out(dso), .dimming_sync_pin_oe_out(dsoe), .lamp_sync_pin_in(lamp_sync_pin),
		.lamp_sync_pin_out(lso), .lamp_sync_pin_oe_out(lsoe), .address_select_pin_in(1'b1), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .gate_a_out(ga), .gate_b_out(gb),
		.burst_modulation_out(burst));
	lamp_peer_model lamp_peer_model_inst (.core_clk_in(clk), .rst_n_in(rst_n), .gate_a_in(ga), .gate_b_in(gb),
		.lamp_en_in(lamp_en), .sense_out(sense), .lamp_clk_out(plamp), .dim_clk_out(pdim));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task w(input int n); repeat (n) @(posedge clk); endtask : w
	task chk(input logic [31:0] g, input logic [31:0] e, input int t);
		cmp_count++;
		if ((t == 0) ? (g !== e) : (g > e + t || g + t < e))
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// s=0 start, s=1 stop.
	task sc(input logic s); w(2); sda_m <= !s; w(10); scl <= 1'b1; w(10); sda_m <= s; w(10); if (!s) scl <= 1'b0; endtask : sc
	task tx(input logic [8:0] t);
		for (int i = 8; i >= 0; i--)
		begin
			w(2); sda_m <= t[i]; w(8); scl <= 1'b1; w(5); rx[i] = sda; w(5); scl <= 1'b0;
		end
	endtask : tx
	task wr(input logic [7:0] a, input logic [7:0] d);
		sc(0); tx({DEV, 2'b01}); tx({a, 1'b1}); tx({d, 1'b1}); chk(rx[0], 0, 0); sc(1);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		sc(0); tx({DEV, 2'b01}); chk(rx[0], 0, 0); tx({a, 1'b1}); sc(0); tx({DEV, 2'b11}); tx(9'h1FF); sc(1);
		chk(rx[8:1], e, 0);
	endtask : rd
	// Burst highs, burst rises, gate A rises.
	task watch(input int n);
		hi = 0; rises = 0; brises = 0; lg = ga[0]; lb = burst;
		repeat (n)
		begin
			@(posedge clk); #1;
			hi += burst; rises += ga[0] && !lg; brises += burst && !lb; lg = ga[0]; lb = burst;
		end
	endtask : watch
	task t_cfg();
		rd(C1, lamp_drive_pkg::CR1_RESET);
		rd(C2, lamp_drive_pkg::CR2_RESET);
		rd(8'h0D, lamp_drive_pkg::USER_RESET);
		wr(8'h0D, 8'h5A); rd(8'h0D, 8'h5A); wr(8'h03, 8'hC3); rd(8'h03, 8'hC3);
		sc(0); tx({DEV ^ 7'h01, 2'b01}); chk(rx[0], 1, 0); sc(1);
	endtask : t_cfg
	task t_duty();
		logic [7:0] c [5];
		int e [5];
		c = '{8'h00, 8'h32, 8'h7D, 8'hC8, 8'hFF};
		e = '{104, 104, 564, 1024, 1024};
		for (int i = 0; i < 5; i++)
		begin
			code <= c[i]; w(2048); watch(1024); chk(hi, e[i], i == 2 ? 8 : 0);
		end
		chk(rises, 16, 0);
	endtask : t_duty
	task t_burst();
		wr(C1, 8'h01); chk(dsoe, 0, 0);
		pburst <= 1'b0; w(20); watch(500); chk(hi + rises, 0, 0);
		pburst <= 1'b1; code <= 8'h00; w(20); watch(500); chk(hi, 500, 0);
		wr(C1, 8'h04); chk(dsoe, 0, 0);
		wr(C1, 8'h00); chk(dsoe, 1, 0);
	endtask : t_burst
	task t_ext();
		code <= 8'hFF; lamp_en <= 1'b1; wr(C1, 8'h08); chk(lsoe, 0, 0);
		w(4000); watch(3000); chk(rises, 2, 0);
		code <= 8'h00; wr(C2, 8'h03); wr(C1, 8'h02);
		w(2000); watch(1600); chk(brises, 2, 0);
		lamp_en <= 1'b0; wr(C1, 8'h00); chk(lsoe, 1, 0);
	endtask : t_ext
	task results();
		$display("mismatches %0d of %0d comparisons", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Main sequence.
	initial
	begin
		rst_n = 1'b0; scl = 1'b1; sda_m = 1'b1; pburst = 1'b0; lamp_en = 1'b0; code = 8'hFF;
		w(16); rst_n <= 1'b1; w(8);
		chk({lsoe, dsoe, sda_oe}, 3'b110, 0);
		t_cfg(); t_duty(); t_burst(); t_ext();
		results();
	end
	// A hang counts as a mismatch.
	initial
	begin
		w(90000); err_total++; results();
	end
endmodule : test_lamp_drive_burst_dimming_control
